// ---- design/cfs_status_bank.sv ----
// read-only controller fault and system status register bank
`timescale 1ns/1ns
`default_nettype none
`include "cfs_defines.svh"

module cfs_status_bank (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire cfs_pkg::cfs_fault_in_t fault_in,
	input wire cfs_pkg::cfs_status_in_t status_in,
	input wire logic [31:0] system_status_word_1_in,
	input wire logic [31:0] system_status_word_2_in,
	input wire logic [31:0] system_status_word_3_in,
	input wire cfs_pkg::cfs_req_t req_in,
	output logic busy_out,
	output var cfs_pkg::cfs_rsp_t rsp_out
);

	// reset release

	logic rst_meta;
	logic rst_n;
	logic next_rst_meta;
	logic next_rst_n;

	always_comb begin
		next_rst_meta = 1'b1;
		next_rst_n = rst_meta;
	end

	// assertion is asynchronous, release waits two edges
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= next_rst_meta;
			rst_n <= next_rst_n;
		end
	end

	// address decode, shared by the read path and the checks

	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr == `CFS_OFS_FAULT) || (addr == `CFS_OFS_SYS1)
			|| (addr == `CFS_OFS_SYS2) || (addr == `CFS_OFS_SYS3);
	endfunction

	function automatic logic [31:0] pick_word(
		input logic [7:0] addr,
		input logic [31:0] fault_w,
		input logic [31:0] sys1,
		input logic [31:0] sys2,
		input logic [31:0] sys3
	);
		case (addr)
			`CFS_OFS_FAULT: pick_word = fault_w;
			`CFS_OFS_SYS1: pick_word = sys1;
			`CFS_OFS_SYS2: pick_word = sys2;
			`CFS_OFS_SYS3: pick_word = sys3;
			default: pick_word = `CFS_RST_WORD;
		endcase
	endfunction

	// controller fault word

	logic [31:0] fault_word;

	cfs_fault_word u_fault_word (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.fault_in(fault_in),
		.status_in(status_in),
		.word_out(fault_word)
	);

	// system status words, sampled every cycle

	logic [31:0] sys_word [3];
	logic [31:0] next_sys_word [3];

	always_comb begin
		next_sys_word[0] = system_status_word_1_in;
		next_sys_word[1] = system_status_word_2_in;
		next_sys_word[2] = system_status_word_3_in;
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				sys_word[i] <= `CFS_RST_WORD; // [RQ16]
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				sys_word[i] <= next_sys_word[i];
			end
		end
	end

	// register port

	cfs_pkg::cfs_state_t state;
	cfs_pkg::cfs_state_t next_state;
	cfs_pkg::cfs_rsp_t next_rsp;
	logic take_rd;
	logic take_wr;

	// a read wins over a write presented in the same cycle
	assign take_rd = (state == cfs_pkg::CFS_IDLE) && req_in.rd;
	assign take_wr = (state == cfs_pkg::CFS_IDLE) && req_in.wr && !req_in.rd;
	assign busy_out = (state != cfs_pkg::CFS_IDLE);

	always_comb begin
		next_state = state;
		next_rsp = rsp_out;
		next_rsp.valid = 1'b0;
		case (state)
			cfs_pkg::CFS_IDLE: begin
				if (take_rd) begin
					next_state = cfs_pkg::CFS_ANSWER;
					next_rsp.valid = 1'b1;
					// unassigned offsets answer zero with an error
					next_rsp.err = !is_mapped(req_in.addr); // [RQ18]
					next_rsp.data = pick_word(req_in.addr, fault_word,
						sys_word[0], sys_word[1], sys_word[2]); // [RQ15] [RQ16]
				end else if (take_wr) begin
					next_state = cfs_pkg::CFS_ANSWER;
					// nothing here is writable, the store is dropped
					next_rsp.valid = 1'b1;
					next_rsp.err = 1'b1; // [RQ17] [RQ19]
					next_rsp.data = `CFS_RST_WORD;
				end
			end
			cfs_pkg::CFS_ANSWER: begin
				// requests in this cycle are not taken
				next_state = cfs_pkg::CFS_IDLE;
			end
			default: begin
				next_state = cfs_pkg::CFS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= cfs_pkg::CFS_IDLE;
			rsp_out <= '{valid: 1'b0, err: 1'b0, data: `CFS_RST_WORD};
		end else begin
			state <= next_state;
			rsp_out <= next_rsp;
		end
	end

	// checks

	default clocking cb @(posedge core_clk_in);
	endclocking

	default disable iff (!rst_n);

	logic past_valid;
	logic next_past_valid;

	always_comb begin
		next_past_valid = 1'b1;
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			past_valid <= 1'b0;
		end else begin
			past_valid <= next_past_valid;
		end
	end

	sequence s_take_read(logic [7:0] a);
		state == cfs_pkg::CFS_IDLE && req_in.rd && req_in.addr == a;
	endsequence

	sequence s_take_write;
		state == cfs_pkg::CFS_IDLE && req_in.wr && !req_in.rd;
	endsequence

	sequence s_answer;
		rsp_out.valid ##1 !rsp_out.valid;
	endsequence

	AST_SUMMARY_OR: assert property ( // [RQ1]
		fault_word[31] == (|fault_word[29:15]))
		else $error("summary bit disagrees with fault flags");

	AST_POSITION_FAULTS: assert property ( // [RQ2] [RQ3]
		past_valid |-> fault_word[29] == $past(fault_in.position_detect_freq_err)
			&& fault_word[28] == $past(fault_in.position_detect_timing_a_err)
			&& fault_word[27] == $past(fault_in.position_detect_timing_b_err))
		else $error("position detect flags do not follow their inputs");

	AST_LOCK_FLAGS: assert property ( // [RQ4] [RQ5] [RQ6]
		past_valid |-> fault_word[23] == $past(fault_in.abnormal_rotation_rate)
			&& fault_word[22] == $past(fault_in.commutation_desync)
			&& fault_word[21] == $past(fault_in.motor_absent))
		else $error("lock detector flags do not follow their inputs");

	AST_LOCK_COMBINED: assert property ( // [RQ7]
		past_valid |-> fault_word[20] == (|fault_word[23:21] || $past(fault_in.rotor_lock_other)))
		else $error("combined lock flag wrong");

	AST_CURRENT_CAPS: assert property ( // [RQ8] [RQ9]
		past_valid && fault_in.per_cycle_current_cap && !fault_in.lock_detect_current_cap
			|=> fault_word[19] && !fault_word[18] && fault_word[31])
		else $error("current cap flags wrong");

	AST_SUPPLY: assert property ( // [RQ10]
		past_valid |-> fault_word[17] == $past(fault_in.supply_low_fault)
			&& fault_word[16] == $past(fault_in.supply_high_fault))
		else $error("supply flags do not follow their inputs");

	AST_WATCHDOG: assert property ( // [RQ11]
		past_valid && $rose(fault_in.external_watchdog_expired) |=> $rose(fault_word[15]) && fault_word[31])
		else $error("watchdog flag missed");

	AST_SELF_TEST: assert property ( // [RQ12] [RQ13] [RQ14]
		past_valid |-> fault_word[2:0] == {$past(status_in.self_test_enabled),
			$past(status_in.self_test_passed), $past(status_in.app_reset_ok)})
		else $error("self-test or reset outcome bits wrong");

	AST_RESERVED_ZERO: assert property ( // [RQ19]
		fault_word[30] == 1'b0 && fault_word[26:24] == 3'h0 && fault_word[14:3] == 12'h000)
		else $error("reserved bit set");

	AST_READ_FAULT: assert property ( // [RQ15]
		s_take_read(`CFS_OFS_FAULT) |=> rsp_out.valid && !rsp_out.err
			&& rsp_out.data == $past(fault_word))
		else $error("fault word read returned wrong data");

	AST_READ_SYS2: assert property ( // [RQ16]
		s_take_read(`CFS_OFS_SYS2) |=> rsp_out.valid && !rsp_out.err
			&& rsp_out.data == $past(sys_word[1]))
		else $error("second status word read returned wrong data");

	AST_READ_UNMAPPED: assert property ( // [RQ18]
		(state == cfs_pkg::CFS_IDLE && req_in.rd && !is_mapped(req_in.addr))
			|=> rsp_out.valid && rsp_out.err && rsp_out.data == 32'h00000000)
		else $error("unmapped read not flagged");

	AST_WRITE_REFUSED: assert property ( // [RQ17] [RQ19]
		s_take_write |=> rsp_out.valid && rsp_out.err && rsp_out.data == 32'h00000000)
		else $error("write not refused");

	AST_ONE_ANSWER: assert property ( // [RQ17]
		(take_rd || take_wr) |=> s_answer)
		else $error("answer not a single cycle pulse");

	AST_STATUS_SAMPLE: assert property ( // [RQ16]
		past_valid |-> sys_word[0] == $past(system_status_word_1_in) && sys_word[2] == $past(system_status_word_3_in))
		else $error("status words not sampled");

	// port handshake: one answer per taken request, none otherwise

	sequence s_take_any;
		take_rd || take_wr;
	endsequence

	sequence s_req_any;
		req_in.rd || req_in.wr;
	endsequence

	sequence s_quiet;
		!rsp_out.valid;
	endsequence

	// read data is the word as held at the taking edge
	AST_READ_SYS1: assert property ( // [RQ16]
		s_take_read(`CFS_OFS_SYS1) |=> rsp_out.valid && !rsp_out.err
			&& rsp_out.data == $past(sys_word[0]))
		else $error("first status word read returned wrong data");

	AST_READ_SYS3: assert property ( // [RQ16]
		s_take_read(`CFS_OFS_SYS3) |=> rsp_out.valid && !rsp_out.err
			&& rsp_out.data == $past(sys_word[2]))
		else $error("third status word read returned wrong data");

	AST_READ_MAPPED_OK: assert property ( // [RQ15] [RQ16]
		(state == cfs_pkg::CFS_IDLE && req_in.rd && is_mapped(req_in.addr)) |=> rsp_out.valid && !rsp_out.err)
		else $error("mapped read answered with an error");

	AST_BUSY_IN_ANSWER: assert property ( // [RQ17]
		rsp_out.valid |-> busy_out)
		else $error("answer given while port idle");

	AST_BUSY_ONE_CYCLE: assert property ( // [RQ17]
		busy_out |=> !busy_out)
		else $error("port busy for more than one cycle");

	AST_STATE_ONEHOT: assert property ( // [RQ17]
		$onehot(state))
		else $error("port state not one-hot");

	AST_NO_STRAY_ANSWER: assert property ( // [RQ17]
		!(take_rd || take_wr) |=> s_quiet)
		else $error("answer without a taken request");

	// a request left standing over the answer cycle must not answer twice
	AST_HELD_NOT_RETAKEN: assert property ( // [RQ17]
		s_take_any ##1 s_req_any |=> s_quiet)
		else $error("request in the answer cycle was taken");

	AST_ANSWER_HOLDS: assert property ( // [RQ17]
		past_valid && !rsp_out.valid |-> $stable(rsp_out.err) && $stable(rsp_out.data))
		else $error("answer fields changed without an answer");

	// summary bit against the raw inputs, not against the other word bits
	AST_SUMMARY_SET: assert property ( // [RQ1]
		past_valid && $past(fault_in) != 12'h000 |-> fault_word[31])
		else $error("summary bit clear with a fault present");

	AST_SUMMARY_CLEAR: assert property ( // [RQ1]
		past_valid && $past(fault_in) == 12'h000 |-> fault_word[31:15] == 17'h00000)
		else $error("fault bits set with no fault present");

	AST_STATUS_NOT_FAULT: assert property ( // [RQ1] [RQ12] [RQ13] [RQ14]
		past_valid && $past(fault_in) == 12'h000 && $past(status_in) != 3'h0 |-> !fault_word[31])
		else $error("status bits leaked into the summary bit");

	AST_LOCK_OTHER: assert property ( // [RQ7]
		past_valid && fault_in.rotor_lock_other |=> fault_word[20] && fault_word[31])
		else $error("unlisted lock type not in combined flag");

	AST_WATCHDOG_FALL: assert property ( // [RQ11]
		past_valid && $fell(fault_in.external_watchdog_expired) |=> !fault_word[15])
		else $error("watchdog flag held after input cleared");

	AST_SUPPLY_SUMMARY: assert property ( // [RQ10] [RQ1]
		past_valid && (fault_in.supply_low_fault || fault_in.supply_high_fault) |=> fault_word[31])
		else $error("supply fault not in summary bit");

	AST_POSITION_SUMMARY: assert property ( // [RQ2] [RQ3] [RQ1]
		past_valid && (fault_in.position_detect_freq_err || fault_in.position_detect_timing_a_err
			|| fault_in.position_detect_timing_b_err) |=> fault_word[31])
		else $error("position detect fault not in summary bit");

endmodule // cfs_status_bank

`default_nettype wire

// ---- common/cfs_defines.svh ----
// offsets, field positions and reset values of the controller fault status bank
// Summary of operation
// (RQ1) bit 31 is OR of all faults
// (RQ2) bit 29 flags position detect frequency fault
// (RQ3) bits 28, 27 flag timing faults a, b
// (RQ4) bit 23 flags abnormal rotation rate lock
// (RQ5) bit 22 flags commutation desync lock
// (RQ6) bit 21 flags motor absent
// (RQ7) bit 20 is OR of lock detectors
// (RQ8) bit 19 flags per-cycle current cap
// (RQ9) bit 18 flags lock detect current cap
// (RQ10) bits 17, 16 flag supply low, high
// (RQ11) bit 15 flags external watchdog expiry
// (RQ12) bit 2 shows self-test enabled
// (RQ13) bit 1 shows self-test passed
// (RQ14) bit 0 shows application reset succeeded
// (RQ15) fault word at E2h, zero on reset
// (RQ16) status words at E4h, EAh, ECh, zero on reset
// (RQ17) every field read-only from reset value
// (RQ18) software never writes unassigned offsets
// (RQ19) reserved bits read zero, writes ignored
`ifndef CFS_DEFINES_SVH
`define CFS_DEFINES_SVH

`define CFS_OFS_FAULT 8'hE2
`define CFS_OFS_SYS1 8'hE4
`define CFS_OFS_SYS2 8'hEA
`define CFS_OFS_SYS3 8'hEC
`define CFS_RST_WORD 32'h00000000

`define CFS_BIT_ANY 31
`define CFS_BIT_FREQ 29
`define CFS_BIT_TIM_A 28
`define CFS_BIT_TIM_B 27
`define CFS_BIT_RATE 23
`define CFS_BIT_DESYNC 22
`define CFS_BIT_ABSENT 21
`define CFS_BIT_LOCK 20
`define CFS_BIT_CYC_CAP 19
`define CFS_BIT_LOCK_CAP 18
`define CFS_BIT_LOW 17
`define CFS_BIT_HIGH 16
`define CFS_BIT_WD 15
`define CFS_BIT_ST_EN 2
`define CFS_BIT_ST_PASS 1
`define CFS_BIT_APP_RST 0

`endif

// ---- common/cfs_pkg.sv ----
// types shared by the controller fault status bank
package cfs_pkg;

	typedef struct packed {
		logic position_detect_freq_err;
		logic position_detect_timing_a_err;
		logic position_detect_timing_b_err;
		logic abnormal_rotation_rate;
		logic commutation_desync;
		logic motor_absent;
		logic rotor_lock_other;
		logic per_cycle_current_cap;
		logic lock_detect_current_cap;
		logic supply_low_fault;
		logic supply_high_fault;
		logic external_watchdog_expired;
	} cfs_fault_in_t;

	typedef struct packed {
		logic self_test_enabled;
		logic self_test_passed;
		logic app_reset_ok;
	} cfs_status_in_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
	} cfs_req_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic [31:0] data;
	} cfs_rsp_t;

	typedef enum logic [1:0] {
		CFS_IDLE = 2'h1,
		CFS_ANSWER = 2'h2
	} cfs_state_t;

endpackage

// ---- design/cfs_fault_word.sv ----
// assembles and registers the controller fault word
`timescale 1ns/1ns
`default_nettype none
`include "cfs_defines.svh"

module cfs_fault_word (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire cfs_pkg::cfs_fault_in_t fault_in,
	input wire cfs_pkg::cfs_status_in_t status_in,
	output logic [31:0] word_out
);

	logic [31:0] next_word;

	always_comb begin
		next_word = `CFS_RST_WORD; // [RQ19]
		next_word[`CFS_BIT_FREQ] = fault_in.position_detect_freq_err; // [RQ2]
		next_word[`CFS_BIT_TIM_A] = fault_in.position_detect_timing_a_err; // [RQ3]
		next_word[`CFS_BIT_TIM_B] = fault_in.position_detect_timing_b_err; // [RQ3]
		next_word[`CFS_BIT_RATE] = fault_in.abnormal_rotation_rate; // [RQ4]
		next_word[`CFS_BIT_DESYNC] = fault_in.commutation_desync; // [RQ5]
		next_word[`CFS_BIT_ABSENT] = fault_in.motor_absent; // [RQ6]
		// lock types without a bit of their own still count here
		next_word[`CFS_BIT_LOCK] = fault_in.abnormal_rotation_rate | fault_in.commutation_desync
			| fault_in.motor_absent | fault_in.rotor_lock_other; // [RQ7]
		next_word[`CFS_BIT_CYC_CAP] = fault_in.per_cycle_current_cap; // [RQ8]
		next_word[`CFS_BIT_LOCK_CAP] = fault_in.lock_detect_current_cap; // [RQ9]
		next_word[`CFS_BIT_LOW] = fault_in.supply_low_fault; // [RQ10]
		next_word[`CFS_BIT_HIGH] = fault_in.supply_high_fault; // [RQ10]
		next_word[`CFS_BIT_WD] = fault_in.external_watchdog_expired; // [RQ11]
		next_word[`CFS_BIT_ST_EN] = status_in.self_test_enabled; // [RQ12]
		next_word[`CFS_BIT_ST_PASS] = status_in.self_test_passed; // [RQ13]
		next_word[`CFS_BIT_APP_RST] = status_in.app_reset_ok; // [RQ14]
		// self-test and reset outcome are status, not faults
		next_word[`CFS_BIT_ANY] = |next_word[`CFS_BIT_FREQ:`CFS_BIT_WD]; // [RQ1]
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_out <= `CFS_RST_WORD; // [RQ15]
		end else begin
			word_out <= next_word;
		end
	end

endmodule // cfs_fault_word

`default_nettype wire

// ---- testbench/cfs_status_bank_test.sv ----
// self-checking testbench of the controller fault status bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module cfs_status_bank_test;
	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	cfs_pkg::cfs_fault_in_t fault_in = '0;
	cfs_pkg::cfs_status_in_t status_in = '0;
	logic [31:0] system_status_word_1_in = 32'h0;
	logic [31:0] system_status_word_2_in = 32'h0;
	logic [31:0] system_status_word_3_in = 32'h0;
	cfs_pkg::cfs_req_t req_in = '0;
	logic busy_out;
	cfs_pkg::cfs_rsp_t rsp_out;
	int n_errors = 0;
	int tests_run = 0;
	logic [32:0] exp_q[$];
	logic [32:0] exp_v;
	logic [15:0] lfsr_state = 16'h8AA4;
	logic [7:0] bad_addr[5] = '{8'hE6, 8'hE3, 8'h00, 8'hFF, 8'hEB};

	cfs_status_bank cfs_status_bank_i (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.fault_in(fault_in),
		.status_in(status_in),
		.system_status_word_1_in(system_status_word_1_in),
		.system_status_word_2_in(system_status_word_2_in),
		.system_status_word_3_in(system_status_word_3_in),
		.req_in(req_in),
		.busy_out(busy_out),
		.rsp_out(rsp_out)
	);

	always #50 core_clk_in = ~core_clk_in;

	function automatic logic [15:0] lfsr_next();
		lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
		return lfsr_state;
	endfunction

	// expected fault word, built bit by bit from the inputs
	function automatic logic [31:0] fw(cfs_pkg::cfs_fault_in_t f, cfs_pkg::cfs_status_in_t s);
		logic [31:0] w;
		w = 32'h0;
		w[29] = f.position_detect_freq_err;
		w[28] = f.position_detect_timing_a_err;
		w[27] = f.position_detect_timing_b_err;
		w[23] = f.abnormal_rotation_rate;
		w[22] = f.commutation_desync;
		w[21] = f.motor_absent;
		w[20] = f.abnormal_rotation_rate | f.commutation_desync | f.motor_absent | f.rotor_lock_other;
		w[19] = f.per_cycle_current_cap;
		w[18] = f.lock_detect_current_cap;
		w[17] = f.supply_low_fault;
		w[16] = f.supply_high_fault;
		w[15] = f.external_watchdog_expired;
		w[31] = |w[29:15];
		w[2] = s.self_test_enabled;
		w[1] = s.self_test_passed;
		w[0] = s.app_reset_ok;
		return w;
	endfunction

	// one access, spaced so the next request never lands in the answer cycle
	task automatic acc(input logic rd, input logic wr, input logic [7:0] a, input logic [32:0] exp);
		@(posedge core_clk_in);
		#10;
		req_in = '{rd: rd, wr: wr, addr: a};
		exp_q.push_back(exp);
		@(posedge core_clk_in);
		#10;
		req_in = '0;
		@(posedge core_clk_in);
	endtask

	task automatic settle();
		repeat (2) @(posedge core_clk_in);
		#10;
	endtask

	task automatic wrap_up();
		if (n_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// answers checked mid-cycle, after the registered outputs settle
	always @(negedge core_clk_in) begin
		if (rsp_out.valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("Error t=%0t got %h exp %h", $time, rsp_out, 34'h0);
			end else begin
				exp_v = exp_q.pop_front();
				`CHK({rsp_out.err, rsp_out.data}, exp_v)
				`CHK(busy_out, 1'b1)
			end
		end
	end

	initial begin
		#(3000 * 100);
		n_errors++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge core_clk_in);
		#10;
		nrst_in = 1'b1;
		repeat (2) @(posedge core_clk_in);
		acc(1'b1, 1'b0, 8'hE2, 33'h0);
		acc(1'b1, 1'b0, 8'hE4, 33'h0);
		acc(1'b1, 1'b0, 8'hEA, 33'h0);
		acc(1'b1, 1'b0, 8'hEC, 33'h0);
		// one fault at a time exposes a swapped or missing bit
		for (int i = 0; i < 12; i++) begin
			#10;
			fault_in = 12'h1 << i;
			status_in = 3'(lfsr_next());
			settle();
			acc(1'b1, 1'b0, 8'hE2, {1'b0, fw(fault_in, status_in)});
		end
		for (int k = 0; k < 16; k++) begin
			#10;
			fault_in = 12'(lfsr_next());
			status_in = 3'(lfsr_next());
			system_status_word_1_in = {lfsr_next(), lfsr_next()};
			system_status_word_2_in = {lfsr_next(), lfsr_next()};
			system_status_word_3_in = {lfsr_next(), lfsr_next()};
			settle();
			acc(1'b1, 1'b0, 8'hE2, {1'b0, fw(fault_in, status_in)});
			acc(1'b1, 1'b0, 8'hE4, {1'b0, system_status_word_1_in});
			acc(1'b1, 1'b0, 8'hEA, {1'b0, system_status_word_2_in});
			acc(1'b1, 1'b0, 8'hEC, {1'b0, system_status_word_3_in});
		end
		// writes are refused and change nothing
		acc(1'b0, 1'b1, 8'hE2, {1'b1, 32'h0});
		acc(1'b0, 1'b1, 8'hEC, {1'b1, 32'h0});
		acc(1'b1, 1'b0, 8'hE2, {1'b0, fw(fault_in, status_in)});
		acc(1'b1, 1'b1, 8'hEA, {1'b0, system_status_word_2_in});
		foreach (bad_addr[j]) begin
			acc(1'b1, 1'b0, bad_addr[j], {1'b1, 32'h0});
		end
		// request held over the answer cycle must be taken once only
		@(posedge core_clk_in);
		#10;
		req_in = '{rd: 1'b1, wr: 1'b0, addr: 8'hE4};
		exp_q.push_back({1'b0, system_status_word_1_in});
		repeat (2) @(posedge core_clk_in);
		#10;
		req_in = '0;
		repeat (2) @(posedge core_clk_in);
		// reset in mid-run with faults present clears the outputs
		#10;
		fault_in = 12'hFFF;
		nrst_in = 1'b0;
		@(negedge core_clk_in);
		`CHK(rsp_out, 34'h0)
		`CHK(busy_out, 1'b0)
		@(posedge core_clk_in);
		#10;
		nrst_in = 1'b1;
		repeat (3) @(posedge core_clk_in);
		acc(1'b1, 1'b0, 8'hE2, {1'b0, fw(fault_in, status_in)});
		repeat (3) @(posedge core_clk_in);
		`CHK(exp_q.size(), 0)
		wrap_up();
	end
endmodule // cfs_status_bank_test

`default_nettype wire
